/* include/rpk_map.vh */
// Constants of the packed twelve-bit raw byte packer.
// Assumes no other header defines the same macro names.
`ifndef RPK_MAP_VH
`define RPK_MAP_VH

`define RPK_CODING_W        8
`define RPK_CODING_PACKED12 8'h87
`define RPK_PIX_W           12
`define RPK_PIX_MAX         12'hfff
`define RPK_HI_MSB          11
`define RPK_HI_LSB          4
`define RPK_LO_MSB          3
`define RPK_LO_LSB          0
`define RPK_BYTE_W          8
`define RPK_GROUP_BYTES     3
`define RPK_FIFO_DEPTH      32
`define RPK_FIFO_AW         5
`define RPK_COLOR_W         2
`define RPK_COLOR_RED       2'h0
`define RPK_COLOR_GREEN     2'h1
`define RPK_COLOR_BLUE      2'h2

`endif

/* hdl/rpk_fifo.v */
// Synchronous FIFO with valid/ready handshakes on both sides.
// Assumes one clock; storage is flip-flops addressed by pointer.
`timescale 1ns/1ps
module rpk_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // rpk_fifo

/* hdl/rpk_site.v */
// Bayer filter site colour for the blue/green, green/red alignment.
// Assumes line and pixel parity come from the packer's counters.
`timescale 1ns/1ps
`include "rpk_map.vh"
module rpk_site (
    input  wire                    line_odd,
    input  wire                    pix_odd,
    output reg [`RPK_COLOR_W-1:0]  color
);
    always @* begin
        case ({line_odd, pix_odd})
            2'b00:   color = `RPK_COLOR_BLUE;
            2'b01:   color = `RPK_COLOR_GREEN;
            2'b10:   color = `RPK_COLOR_GREEN;
            2'b11:   color = `RPK_COLOR_RED;
            default: color = `RPK_COLOR_GREEN;
        endcase
    end
endmodule // rpk_site

/* hdl/rpk_packer.v */
// Packs raw twelve-bit Bayer samples, two pixels into three bytes.
// Assumes pixels arrive with valid/ready, a line end flag on the last
// pixel, and an even pixel count per line; bytes leave through a FIFO.
//
// Contract
// - Packing runs only while the selected colour coding equals 135; the code gates only pixel intake, and that one cycle after the coding changes.
// - Each pixel contributes exactly twelve bits of sample data.
// - Each pixel pair becomes three consecutive bytes without padding.
// - Samples pass through unchanged, never interpolated.
// - Each value is its own pixel's red, green or blue sample alone.
// - Even lines carry blue at even and green at odd positions.
// - Odd lines carry green at even and red at odd positions.
// - The first byte holds bits 11 to 4 of the even pixel.
// - The second byte holds bits 3 to 0 of both pixels.
// - The third byte holds bits 11 to 4 of the odd pixel.
// - Groups follow in pixel order and a line ends on its last high byte.
// - Samples are unsigned twelve-bit values from 0 to 0fff.
`timescale 1ns/1ps
`include "rpk_map.vh"
module rpk_packer (
    input  wire                       clk,
    input  wire                       rstn,
    input  wire [`RPK_CODING_W-1:0]   coding,
    input  wire [`RPK_PIX_W-1:0]      pix_data,
    input  wire                       pix_valid,
    input  wire                       pix_last,
    input  wire                       frame_start,
    output reg                        pix_ready,
    output reg  [`RPK_BYTE_W-1:0]     byte_data,
    output reg                        byte_valid,
    output reg                        byte_last,
    output reg  [`RPK_COLOR_W-1:0]    byte_color,
    input  wire                       byte_ready,
    output reg                        odd_line_err
);
    // Two collecting states, then one state per byte of the group
    localparam [2:0] ST_EVEN = 3'd0;
    localparam [2:0] ST_ODD  = 3'd1;
    localparam [2:0] ST_HI   = 3'd2;
    localparam [2:0] ST_MID  = 3'd3;
    localparam [2:0] ST_LAST = 3'd4;

    // Control
    reg  [2:0]                st_q;
    reg  [2:0]                st_d;
    reg                       ready_d;
    wire                      enabled;
    wire                      take;
    wire                      take_even;
    wire                      take_odd;
    wire                      pix_odd;

    // Pair held between collection and write-out
    reg  [`RPK_PIX_W-1:0]     even_q;
    reg  [`RPK_PIX_W-1:0]     odd_q;
    reg                       line_odd_q;
    reg                       last_q;
    reg  [`RPK_COLOR_W-1:0]   even_col_q;
    reg  [`RPK_COLOR_W-1:0]   odd_col_q;
    wire [`RPK_COLOR_W-1:0]   site_col;

    // FIFO write side
    reg  [`RPK_BYTE_W-1:0]    f_data;
    reg                       f_valid;
    reg                       f_last;
    reg  [`RPK_COLOR_W-1:0]   f_col;
    wire                      f_ready;

    // FIFO read side
    wire [`RPK_BYTE_W+2:0]    q_data;
    wire                      q_valid;
    wire                      q_ready;

    assign enabled   = (coding == `RPK_CODING_PACKED12);
    assign take      = pix_valid & pix_ready;
    assign pix_odd   = (st_q == ST_ODD);
    assign take_even = take & (st_q == ST_EVEN);
    assign take_odd  = take & pix_odd;
    assign q_ready   = byte_ready | ~byte_valid;

    // Filter colour of the pixel position being collected
    rpk_site u_site (
        .line_odd (line_odd_q),
        .pix_odd  (pix_odd),
        .color    (site_col)
    );

    // Collect a pair, then write its three bytes one per cycle while the FIFO has room
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_EVEN: begin
                if (take) begin
                    st_d = ST_ODD;
                end
            end
            ST_ODD: begin
                if (take) begin
                    st_d = ST_HI;
                end
            end
            ST_HI: begin
                if (f_ready) begin
                    st_d = ST_MID;
                end
            end
            ST_MID: begin
                if (f_ready) begin
                    st_d = ST_LAST;
                end
            end
            ST_LAST: begin
                if (f_ready) begin
                    st_d = ST_EVEN;
                end
            end
            default: begin
                st_d = ST_EVEN;
            end
        endcase
    end

    // Ready only while collecting, so a taken pixel never waits on the FIFO
    always @* begin
        ready_d = 1'b0;
        if (enabled) begin
            if (st_d == ST_EVEN || st_d == ST_ODD) begin
                ready_d = 1'b1;
            end
        end
    end

    // Registered ready; a coding change shows one cycle later
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pix_ready <= 1'b0;
        end else begin
            pix_ready <= ready_d;
        end
    end

    // State register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_EVEN;
        end else begin
            st_q <= st_d;
        end
    end

    // FIFO write side: high even, shared low nibbles, high odd
    always @* begin
        f_valid = 1'b0;
        f_data  = {`RPK_BYTE_W{1'b0}};
        f_last  = 1'b0;
        f_col   = even_col_q;
        case (st_q)
            ST_HI: begin
                f_valid = 1'b1;
                f_data  = even_q[`RPK_HI_MSB:`RPK_HI_LSB];
            end
            ST_MID: begin
                f_valid = 1'b1;
                f_data  = {odd_q[`RPK_LO_MSB:`RPK_LO_LSB],
                           even_q[`RPK_LO_MSB:`RPK_LO_LSB]};
            end
            ST_LAST: begin
                f_valid = 1'b1;
                f_data  = odd_q[`RPK_HI_MSB:`RPK_HI_LSB];
                f_last  = last_q;
                f_col   = odd_col_q;
            end
            default: begin
                f_valid = 1'b0;
            end
        endcase
    end

    // Even sample of the pair, kept unaltered
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            even_q <= {`RPK_PIX_W{1'b0}};
        end else if (take_even) begin
            even_q <= pix_data;
        end
    end

    // Filter colour of the even sample
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            even_col_q <= `RPK_COLOR_BLUE;
        end else if (take_even) begin
            even_col_q <= site_col;
        end
    end

    // Odd sample of the pair, kept unaltered
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            odd_q <= {`RPK_PIX_W{1'b0}};
        end else if (take_odd) begin
            odd_q <= pix_data;
        end
    end

    // Filter colour of the odd sample
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            odd_col_q <= `RPK_COLOR_GREEN;
        end else if (take_odd) begin
            odd_col_q <= site_col;
        end
    end

    // Line end travels with the high byte of the odd sample
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_q <= 1'b0;
        end else if (take_odd) begin
            last_q <= pix_last;
        end
    end

    // A line end on an even position breaks the pair layout
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            odd_line_err <= 1'b0;
        end else if (take_even) begin
            odd_line_err <= pix_last;
        end
    end

    // Line parity picks the filter row; frame start in ST_EVEN forces even
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_odd_q <= 1'b0;
        end else if (frame_start && st_q == ST_EVEN) begin
            line_odd_q <= 1'b0;
        end else if (take_odd && pix_last) begin
            line_odd_q <= ~line_odd_q;
        end
    end

    // Byte queue towards the link, colour and line end alongside
    rpk_fifo #(
        .WIDTH (`RPK_BYTE_W + 3),
        .DEPTH (`RPK_FIFO_DEPTH),
        .AW    (`RPK_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_data   ({f_last, f_col, f_data}),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .out_data  (q_data),
        .out_valid (q_valid),
        .out_ready (q_ready)
    );

    // Output register: holds its byte until the sink takes it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byte_valid <= 1'b0;
        end else if (q_ready) begin
            byte_valid <= q_valid;
        end
    end

    // Byte value
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byte_data <= {`RPK_BYTE_W{1'b0}};
        end else if (q_ready && q_valid) begin
            byte_data <= q_data[`RPK_BYTE_W-1:0];
        end
    end

    // Colour of the even sample for the first two bytes, of the odd sample for the third
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byte_color <= `RPK_COLOR_BLUE;
        end else if (q_ready && q_valid) begin
            byte_color <= q_data[`RPK_BYTE_W+1:`RPK_BYTE_W];
        end
    end

    // Marks the final byte of a line
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byte_last <= 1'b0;
        end else if (q_ready && q_valid) begin
            byte_last <= q_data[`RPK_BYTE_W+2];
        end
    end
endmodule // rpk_packer

/* tb/rpk_packer_props.sv */
// Port checker for the raw twelve-bit byte packer.
// Assumes it is bound to the packer top and sees only its ports.
`timescale 1ns/1ps
module rpk_packer_props (
    input logic       clk,
    input logic       rstn,
    input logic [7:0] coding,
    input logic       pix_ready,
    input logic [7:0] byte_data,
    input logic       byte_valid,
    input logic       byte_last,
    input logic [1:0] byte_color,
    input logic       byte_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [1:0] pos_q;
    logic [1:0] col_q;
    wire        take = byte_valid && byte_ready;
    // Byte position within the current three-byte group
    always @(posedge clk or negedge rstn)
        if (!rstn) begin
            pos_q <= 2'h0;
            col_q <= 2'h0;
        end else if (take) begin
            pos_q <= (pos_q == 2'h2) ? 2'h0 : pos_q + 2'h1;
            if (pos_q == 2'h0)
                col_q <= byte_color;
        end
    coding_gate_a: assert property (
        (coding != 8'h87) [*2] |-> !pix_ready) else $error("ready off");
    byte_hold_a: assert property (
        byte_valid && !byte_ready |=> byte_valid && $stable(byte_data)
        && $stable(byte_last)) else $error("byte changed while held");
    color_legal_a: assert property (
        byte_valid |-> byte_color != 2'h3) else $error("bad colour");
    group_first_a: assert property (
        byte_valid && pos_q == 2'h0 |-> byte_color != 2'h0)
        else $error("first byte colour");
    group_mid_a: assert property (
        byte_valid && pos_q == 2'h1 |-> byte_color == col_q)
        else $error("middle byte colour");
    group_third_a: assert property (
        byte_valid && pos_q == 2'h2 |-> byte_color != 2'h2)
        else $error("third byte colour");
    last_pos_a: assert property (
        byte_valid && byte_last |-> pos_q == 2'h2)
        else $error("line end mid group");
    mid_nolast_a: assert property (
        byte_valid && pos_q != 2'h2 |-> !byte_last)
        else $error("early line end");
endmodule // rpk_packer_props

bind rpk_packer rpk_packer_props chk_u (.clk, .rstn, .coding,
    .pix_ready, .byte_data, .byte_valid, .byte_last, .byte_color,
    .byte_ready);

/* tb/rpk_sink.sv */
// Host image buffer model: takes bytes unless told to stall.
// Assumes the bench changes stall on the falling edge.
`timescale 1ns/1ps
module rpk_sink (
    input  logic       clk,
    input  logic       rstn,
    input  logic       stall,
    input  logic [7:0] byte_data,
    input  logic       byte_valid,
    input  logic       byte_last,
    input  logic [1:0] byte_color,
    output logic       byte_ready
);
    logic [10:0] got[$];
    initial byte_ready = 1'b0;
    always @(negedge clk)
        byte_ready <= rstn && !stall;
    always @(posedge clk)
        if (byte_valid && byte_ready)
            got.push_back({byte_last, byte_color, byte_data});
endmodule // rpk_sink

/* tb/rpk_packer_tb.sv */
// Self-checking bench of the raw twelve-bit byte packer.
// Assumes the sink model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "rpk_map.vh"
module rpk_packer_tb;
    logic        clk, rstn, pix_valid, pix_last, stall, pix_ready;
    logic        byte_valid, byte_last, byte_ready, odd_line_err;
    logic [7:0]  coding, byte_data;
    logic [11:0] pix_data;
    logic [1:0]  byte_color;
    logic [10:0] exq[$];
    int          error_cnt, n_compared;

    rpk_packer dut_u (.clk, .rstn, .coding, .pix_data, .pix_valid,
        .pix_last, .frame_start(1'b0), .pix_ready, .byte_data,
        .byte_valid, .byte_last, .byte_color, .byte_ready,
        .odd_line_err);
    rpk_sink sink_u (.clk, .rstn, .stall, .byte_data, .byte_valid,
        .byte_last, .byte_color, .byte_ready);

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    task chk(input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Offers one line and queues the bytes it should become
    task send_line(input int n, input logic [11:0] base, step,
                   input logic odd);
        logic [11:0] v, e;
        logic [1:0]  ce, co;
        int          k;
        ce = odd ? `RPK_COLOR_GREEN : `RPK_COLOR_BLUE;
        co = odd ? `RPK_COLOR_RED : `RPK_COLOR_GREEN;
        for (int i = 0; i < n; i++) begin
            v = base + step * i[11:0];
            @(negedge clk);
            pix_valid = 1;
            pix_data = v;
            pix_last = (i == n - 1);
            k = 0;
            while (pix_ready !== 1'b1 && k < 2000) begin
                @(negedge clk);
                k++;
            end
            @(posedge clk);
            if (i % 2 == 0)
                e = v;
            else begin
                exq.push_back({1'b0, ce, e[11:4]});
                exq.push_back({1'b0, ce, v[3:0], e[3:0]});
                exq.push_back({pix_last, co, v[11:4]});
            end
        end
        @(negedge clk);
        pix_valid = 0;
        pix_last = 0;
    endtask

    task drain(input int n);
        int k;
        k = 0;
        while (sink_u.got.size() < n && k < 3000) begin
            @(negedge clk);
            k++;
        end
        repeat (20) @(negedge clk);
        chk(11'(sink_u.got.size()), 11'(n));
        while (exq.size() > 0 && sink_u.got.size() > 0)
            chk(sink_u.got.pop_front(), exq.pop_front());
        exq.delete();
    endtask

    task t_even; // Even line, full-scale and wrapped values
        send_line(4, 12'hfff, 12'hc5b, 1'b0);
        drain(6);
    endtask

    task t_gate; // Offered pixel must be refused with another coding
        @(negedge clk);
        coding = 8'h00;
        @(negedge clk);
        pix_valid = 1;
        repeat (10) begin
            @(negedge clk);
            chk(11'(pix_ready), 11'h0);
        end
        pix_valid = 0;
        coding = `RPK_CODING_PACKED12;
    endtask

    task t_odd;
        send_line(2, 12'h000, 12'h9e7, 1'b1);
        drain(3);
    endtask

    task t_stall; // Sink stalls until the buffer refuses pixels
        stall = 1;
        fork
            send_line(24, 12'h123, 12'h0f1, 1'b0);
            begin
                repeat (300) @(negedge clk);
                chk(11'(pix_ready), 11'h0);
                stall = 0;
            end
        join
        drain(36);
    endtask

    initial begin
        rstn = 0;
        coding = `RPK_CODING_PACKED12;
        pix_data = 0;
        pix_valid = 0;
        pix_last = 0;
        stall = 0;
        error_cnt = 0;
        n_compared = 0;
        repeat (6) @(negedge clk);
        rstn = 1;
        t_even;
        t_gate;
        t_odd;
        t_stall;
        chk(11'(odd_line_err), 11'h0);
        stop_test;
    end

    initial begin
        #200000;
        error_cnt++;
        stop_test;
    end
endmodule // rpk_packer_tb
